// ---- include/adc_readout_pkg.sv ----
package adc_readout_pkg;

    // Master clock and nominal output data rate
    localparam int CLK_HZ = 50_000_000;
    localparam int DATA_RATE_SPS = 250;
    localparam int DATA_PERIOD_CYC = CLK_HZ / DATA_RATE_SPS;

    // Power-on count is two to this power of master clocks
    localparam int POR_EXP = 16;
    localparam int POR_CYC = 2 ** POR_EXP;

    // FIR settling: 62.98046875 data periods (kept times 256) plus 468 clocks
    localparam longint FIR_SETTLE_PERIODS_X256 = 16123;
    localparam int FIR_SETTLE_CLKS = 468;

    // Sinc settling and continuous-sync blanking, in data periods
    localparam int SETTLE_PERIODS = 63;

    // Data-ready high pulse at each update, in master clocks
    localparam int READY_HIGH_CYC = 4;

    // Serial port figures
    localparam int WORD_BITS = 32;
    localparam int OPCODE_BITS = 8;
    localparam int TIMEOUT_PERIODS = 64;
    localparam int FIFO_DEPTH = 8;

    // Command opcodes; values are arbitrary, 8'h00 must stay a no-op
    localparam logic [7:0] OP_RESUME = 8'h02;
    localparam logic [7:0] OP_STANDBY = 8'h04;
    localparam logic [7:0] OP_SYNC = 8'h08;
    localparam logic [7:0] OP_RESET = 8'h06;
    localparam logic [7:0] OP_START_STREAM = 8'h10;
    localparam logic [7:0] OP_STOP_STREAM = 8'h11;
    localparam logic [7:0] OP_READ = 8'h12;

    // Output codes and FIR clip limits
    localparam logic [31:0] POS_CLIP = 32'h7FFFFFFF;
    localparam logic [31:0] NEG_CLIP = 32'h80000000;
    localparam logic signed [32:0] FIR_MAX = 33'sh03FFFFFFF;
    localparam logic signed [32:0] FIR_MIN = 33'sh1C0000000;

    // Reset values of the configuration bits
    localparam logic STREAM_RESET = 1'b1;
    localparam logic STANDBY_RESET = 1'b0;

    // Filter result as handed over by the decimator
    typedef struct packed {
        logic valid;
        logic signed [32:0] value;
    } sample_t;

    // Serial inputs from the host
    typedef struct packed {
        logic sclk;
        logic din;
    } serial_in_t;

endpackage : adc_readout_pkg

// ---- rtl/adc_readout_ctrl.sv ----
// Operation
// R01 - Reset pin low holds device in reset
// R02 - Reset command acts after eighth clock rise
// R03 - Reset restores defaults and resynchronizes conversions
// R04 - FIR first result after settle time
// R05 - Host keeps sync phases two clocks
// R06 - Continuous-sync syncs on first sync rise
// R07 - Power-down pin resets registers, outputs driven
// R08 - Standby keeps port, stops conversions
// R09 - Count 2^16 clocks after supplies valid
// R10 - Sample input rising, change output falling
// R11 - Serial clock idle 64 periods resets port
// R12 - Host holds input low while streaming
// R13 - Host finishes read before next update
// R14 - Command read overlaps update without corruption
// R15 - Ready falls on result, rises first fall
// R16 - Unread ready pulses high four clocks
// R17 - 32-bit words, LSB redundant sign bit
// R18 - FIR saturates at full-scale codes
// R19 - Sinc results halved, no clipping
// R20 - Readout may stop after 24 bits
// R21 - Streaming default, entered by start command
// R22 - MSB out at ready, then zeros
// R23 - Resync after sync rise or command
// R24 - Continuous-sync keeps ready, zeros 63 periods
// R25 - Stop command suppresses ready, read command
// R26 - Opcodes and results MSB first, eight bits
`timescale 1ns/1ns

// Plain FIFO, registered storage
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Word storage
    logic [AW-1:0] wr_ptr;          // Next slot to fill
    logic [AW-1:0] rd_ptr;          // Oldest word
    logic [AW:0] count;             // Words held

    // Pointer wrap relies on a power-of-two depth
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("sample_fifo depth must be a power of two");
        end
    end

    assign in_ready = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Storage write
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW + 1)'(in_valid && in_ready) - (AW + 1)'(out_valid && out_ready);
        end
    end
endmodule : sample_fifo

module adc_readout_ctrl
    import adc_readout_pkg::*;
#(
    parameter int PERIOD_CYC = DATA_PERIOD_CYC,
    parameter int POR_COUNT = POR_CYC,
    parameter int FIR_SETTLE_CYC =
        int'((longint'(DATA_PERIOD_CYC) * FIR_SETTLE_PERIODS_X256 + 255) / 256)
        + FIR_SETTLE_CLKS,
    parameter int SINC_SETTLE_CYC = SETTLE_PERIODS * DATA_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_pin_n,
    input wire logic powerdown_n,
    input wire logic supply_ok,
    input wire logic sync_pin,
    input wire serial_in_t serial_in,
    input wire logic filter_fir,
    input wire logic cont_sync_mode,
    input wire sample_t sample,
    output logic sample_ready,
    output logic dout,
    output logic result_ready_n
);
    // Elaboration checks on the timing figures
    initial begin
        if (PERIOD_CYC <= READY_HIGH_CYC + 1 || POR_COUNT < 1 || FIR_SETTLE_CYC < 1) begin
            $error("adc_readout_ctrl timing parameters out of range");
        end
    end

    localparam int NPIN = 6;

    logic [NPIN-1:0] pin_raw;    // Asynchronous pins
    logic [NPIN-1:0] pin_meta;   // First stage, read only by second
    logic [NPIN-1:0] pin_s;      // Synchronised pins
    logic sclk_d;                // Previous synced serial clock
    logic sync_d;                // Previous synced sync pin
    logic sclk_rise;
    logic sclk_fall;
    logic sync_rise;

    assign pin_raw = {supply_ok, powerdown_n, reset_pin_n, sync_pin, serial_in.sclk,
                      serial_in.din};

    // Two flops per pin before any logic
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    pin_meta[gi] <= 1'b0;
                    pin_s[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_s[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    logic din_s;
    logic sclk_s;
    logic sync_s;
    logic reset_pin_s;
    logic powerdown_s;
    logic supply_s;
    assign {supply_s, powerdown_s, reset_pin_s, sync_s, sclk_s, din_s} = pin_s;

    // Edge history of the sampled link clock and sync
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            sync_d <= sync_s;
        end
    end
    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign sync_rise = sync_s && !sync_d;

    // Power-on counter restarts whenever a supply drops
    logic [31:0] por_cnt;
    logic por_busy;
    always_ff @(posedge clk) begin
        if (!rst_n || !supply_s) begin
            por_cnt <= 32'(POR_COUNT);  // see R09
        end else if (por_cnt != '0) begin
            por_cnt <= por_cnt - 1'b1;
        end
    end
    assign por_busy = (por_cnt != '0);

    // Internal reset: pin held as long as low, power-down, command pulse
    logic cmd_reset;
    logic core_rst;
    assign core_rst = !rst_n || por_busy || !reset_pin_s || !powerdown_s  // see R01 R07
                      || cmd_reset;  // see R02

    // Command shifter, MSB first on sampled rising edges
    logic [OPCODE_BITS-1:0] cmd_shift;
    logic [2:0] cmd_bits;
    logic port_reset;
    logic op_done;
    logic [OPCODE_BITS-1:0] op;
    assign op = {cmd_shift[OPCODE_BITS-2:0], din_s};
    assign op_done = sclk_rise && (cmd_bits == 3'h7);
    always_ff @(posedge clk) begin
        if (core_rst || port_reset) begin
            cmd_shift <= '0;
            cmd_bits <= '0;
        end else if (sclk_rise) begin
            cmd_shift <= op;  // see R10 R26
            cmd_bits <= cmd_bits + 1'b1;
        end
    end

    // Reset command acts on the next master edge as a pulse of one master clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_reset <= 1'b0;
        end else begin
            cmd_reset <= op_done && (op == OP_RESET);  // see R02
        end
    end

    // Configuration bits, defaults on any internal reset
    logic stream_mode;
    logic standby;
    always_ff @(posedge clk) begin
        if (core_rst) begin
            stream_mode <= STREAM_RESET;  // see R03 R07 R21
            standby <= STANDBY_RESET;
        end else if (op_done) begin
            // Standby touches nothing else: port and modes kept
            unique case (op)
                OP_START_STREAM: stream_mode <= 1'b1;  // see R21
                OP_STOP_STREAM: stream_mode <= 1'b0;   // see R25
                OP_STANDBY: standby <= 1'b1;           // see R08
                OP_RESUME: standby <= 1'b0;
                default: ;
            endcase
        end
    end

    // Continuous-sync: first rise always syncs, later ones only off phase
    logic cs_armed;
    logic [31:0] phase;
    logic resync;
    always_ff @(posedge clk) begin
        if (core_rst || !cont_sync_mode) begin
            cs_armed <= 1'b0;
        end else if (sync_rise) begin
            cs_armed <= 1'b1;  // see R06
        end
    end
    assign resync = (sync_rise && (!cont_sync_mode || !cs_armed || phase != '0))  // see R23
                    || (op_done && (op == OP_SYNC || op == OP_RESUME));

    // Data period timer, restarted by every resync
    logic tick;
    assign tick = (phase == 32'(PERIOD_CYC - 1)) && !standby;
    always_ff @(posedge clk) begin
        if (core_rst || resync) begin
            phase <= '0;  // see R03
        end else if (!standby) begin
            phase <= tick ? '0 : phase + 1'b1;  // see R08
        end
    end

    // Settling window after reset or resync
    logic [31:0] settle_cnt;
    logic settling;
    always_ff @(posedge clk) begin
        if (core_rst || resync) begin
            settle_cnt <= filter_fir ? 32'(FIR_SETTLE_CYC) : 32'(SINC_SETTLE_CYC);  // see R04
        end else if (settle_cnt != '0 && !standby) begin
            settle_cnt <= settle_cnt - 1'b1;
        end
    end
    assign settling = (settle_cnt != '0);

    // Result formatting; in-range FIR words carry the sign again in the LSB
    logic [31:0] fmt_word;
    always_comb begin
        if (!filter_fir) begin
            fmt_word = sample.value[31:0];  // see R19
        end else if (sample.value > FIR_MAX) begin
            fmt_word = POS_CLIP;  // see R18
        end else if (sample.value < FIR_MIN) begin
            fmt_word = NEG_CLIP;
        end else begin
            fmt_word = {sample.value[30:0], sample.value[32]};  // see R17 R18
        end
    end

    // Buffer between the filter and the readout register
    logic fifo_in_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [WORD_BITS-1:0] fifo_word;
    logic [5:0] bits_left;
    logic read_busy;
    assign read_busy = !stream_mode && (bits_left != '0);
    assign fifo_pop = tick && !read_busy;  // see R14
    assign sample_ready = fifo_in_ready && !standby && !core_rst;

    sample_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(core_rst || resync),
        .in_valid(sample.valid && !standby),
        .in_ready(fifo_in_ready),
        .in_data(fmt_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_word)
    );

    // Idle timeout: count updates while the serial clock rests low
    logic [6:0] idle_periods;
    always_ff @(posedge clk) begin
        if (core_rst || sclk_s) begin
            idle_periods <= '0;
        end else if (tick) begin
            idle_periods <= (idle_periods == 7'(TIMEOUT_PERIODS - 1)) ? '0
                            : idle_periods + 1'b1;
        end
    end
    assign port_reset = tick && !sclk_s && (idle_periods == 7'(TIMEOUT_PERIODS - 1));  // see R11

    // Read request, served at the next update
    logic read_pending;
    always_ff @(posedge clk) begin
        if (core_rst || port_reset) begin
            read_pending <= 1'b0;
        end else if (op_done && op == OP_READ) begin
            read_pending <= 1'b1;  // see R25
        end else if (fifo_pop && fifo_valid) begin
            read_pending <= 1'b0;
        end
    end

    // Output shifter and data-ready line
    logic [WORD_BITS-1:0] shift;
    logic publish;
    logic drop;
    // Pulse-sync settling hides results; continuous-sync shows zeros
    assign drop = settling && !cont_sync_mode;  // see R04
    assign publish = fifo_pop && fifo_valid && !drop && (stream_mode || read_pending);
    always_ff @(posedge clk) begin
        if (core_rst) begin
            shift <= '0;
            bits_left <= '0;
            dout <= 1'b0;  // see R07
            result_ready_n <= 1'b1;
        end else if (publish) begin
            shift <= settling ? '0 : fifo_word;  // see R24
            dout <= settling ? 1'b0 : fifo_word[WORD_BITS-1];  // see R22
            bits_left <= 6'(WORD_BITS);
            result_ready_n <= 1'b0;  // see R15
        end else if (port_reset || (op_done && op == OP_READ)) begin
            // A new read drops any truncated word
            bits_left <= '0;  // see R20
            dout <= 1'b0;
        end else begin
            if (phase == 32'(PERIOD_CYC - 1 - READY_HIGH_CYC) || !stream_mode && !read_pending
                && bits_left == '0) begin
                result_ready_n <= 1'b1;  // see R16 R25
            end else if (sclk_fall) begin
                result_ready_n <= 1'b1;  // see R15
            end
            if (sclk_fall && bits_left != '0) begin
                shift <= {shift[WORD_BITS-2:0], 1'b0};  // see R10 R26
                dout <= (bits_left == 6'h01) ? 1'b0 : shift[WORD_BITS-2];  // see R22
                bits_left <= bits_left - 1'b1;
            end
        end
    end
endmodule : adc_readout_ctrl

// ---- verification/adc_readout_monitor.sv ----
`timescale 1ns/1ns

// Port-level timing checks of the readout block
module adc_readout_monitor
    import adc_readout_pkg::*;
#(
    parameter int PERIOD_CYC = 400,
    parameter int POR_COUNT = 8,
    parameter int FIR_SETTLE_CYC = 1000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_pin_n,
    input wire logic powerdown_n,
    input wire logic supply_ok,
    input wire logic sync_pin,
    input wire serial_in_t serial_in,
    input wire logic filter_fir,
    input wire logic cont_sync_mode,
    input wire sample_t sample,
    input wire logic sample_ready,
    input wire logic dout,
    input wire logic result_ready_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rdy_q, sclk_q, sync_q; // Last sampled levels
    logic [15:0] por_cnt; // Clocks with supplies good
    logic [15:0] gap; // Clocks since the last publish
    logic [15:0] sync_cnt; // Clocks since a sync rise
    logic [5:0] fall_cnt; // Serial clock falls since the last publish

    // Edge history
    always_ff @(posedge clk) begin
        rdy_q <= result_ready_n;
        sclk_q <= serial_in.sclk;
        sync_q <= sync_pin;
    end

    // Counters saturate so a long idle never wraps into a false window
    always_ff @(posedge clk) begin
        if (!rst_n || !supply_ok) por_cnt <= 16'h0000;
        else if (por_cnt != 16'hFFFF) por_cnt <= por_cnt + 16'h0001;
        if (!rst_n) gap <= 16'hFFFF;
        else if (rdy_q && !result_ready_n) gap <= 16'h0000;
        else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
        if (!rst_n) sync_cnt <= 16'hFFFF;
        else if (sync_pin && !sync_q) sync_cnt <= 16'h0000;
        else if (sync_cnt != 16'hFFFF) sync_cnt <= sync_cnt + 16'h0001;
        if (!rst_n || (rdy_q && !result_ready_n)) fall_cnt <= 6'h00;
        else if (sclk_q && !serial_in.sclk && fall_cnt != 6'h3F) fall_cnt <= fall_cnt + 6'h01;
    end

    pin_reset_a: assert property (!reset_pin_n [*5] |->
        result_ready_n && !dout && !sample_ready) else $error("reset pin not honoured");
    power_down_a: assert property (!powerdown_n [*5] |->
        result_ready_n && !dout && !sample_ready) else $error("power down not honoured");
    por_hold_a: assert property (supply_ok && por_cnt < POR_COUNT |-> !sample_ready)
        else $error("samples taken before power-on count");
    pulse_high_a: assert property ($rose(result_ready_n) |-> result_ready_n [*4])
        else $error("ready high pulse too short");
    ready_clear_a: assert property (!result_ready_n && $fell(serial_in.sclk)
        |-> ##[1:4] result_ready_n) else $error("ready not cleared by first fall");
    tail_zero_a: assert property ($rose(fall_cnt == 6'h20) |-> ##5 !dout)
        else $error("data out not low after word");
    update_gap_a: assert property ($fell(result_ready_n) |-> gap >= PERIOD_CYC - 1)
        else $error("publishes closer than one period");
    sync_quiet_a: assert property (sync_cnt > 16'h0004 && sync_cnt < FIR_SETTLE_CYC
        && filter_fir && !cont_sync_mode |-> !$fell(result_ready_n))
        else $error("result published inside settle window");

    cover property ($rose(result_ready_n) ##4 $fell(result_ready_n));
    cover property (fall_cnt == 6'h28);
    cover property ($rose(sync_pin));
endmodule : adc_readout_monitor

bind adc_readout_ctrl adc_readout_monitor #(.PERIOD_CYC(PERIOD_CYC), .POR_COUNT(POR_COUNT),
    .FIR_SETTLE_CYC(FIR_SETTLE_CYC)) mon_u (.clk(clk), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .powerdown_n(powerdown_n), .supply_ok(supply_ok),
    .sync_pin(sync_pin), .serial_in(serial_in), .filter_fir(filter_fir),
    .cont_sync_mode(cont_sync_mode), .sample(sample), .sample_ready(sample_ready),
    .dout(dout), .result_ready_n(result_ready_n));

// ---- verification/host_model.sv ----
`timescale 1ns/1ns

// Host on the serial port: drives clock and data in, collects data out
module host_model
    import adc_readout_pkg::*;
(
    input wire logic clk,
    input wire logic dout,
    output serial_in_t serial_in
);
    int half = 4; // Half period in master clocks; 4 gives 80 ns, larger is a slow host

    initial serial_in = '0; // Clock idles low between transfers

    // Shift bits most significant first; tx left aligned, rx right aligned
    task automatic shift(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
        rx = '0;
        for (int k = 0; k < nbits; k++) begin
            serial_in.din = tx[39 - k]; // Opcode bits in order
            repeat (half) @(posedge clk);
            #1 serial_in.sclk = 1'b1; // Device takes din on this rise
            repeat (half) @(posedge clk);
            rx = {rx[38:0], dout}; // Taken late in the high phase, before the next shift
            #1 serial_in.sclk = 1'b0;
        end
        serial_in.din = 1'b0; // Low whenever no opcode is sent
    endtask : shift
endmodule : host_model

// ---- verification/tb.sv ----
`timescale 1ns/1ns

// Self-checking bench for the readout block
module tb;
    import adc_readout_pkg::*;
    localparam int PER = 400; // Shortened update period, room for a full read
    localparam int SETTLE = 1000; // Shortened settle windows
    logic clk, rst_n, reset_pin_n, powerdown_n, supply_ok, sync_pin, filter_fir;
    logic cont_sync_mode, sample_ready, dout, result_ready_n;
    serial_in_t serial_in;
    sample_t sample;
    int n_fail, compares, seed, n;
    logic [39:0] rx;
    logic signed [32:0] v;
    logic signed [32:0] vals [8];

    adc_readout_ctrl #(.PERIOD_CYC(PER), .POR_COUNT(8), .FIR_SETTLE_CYC(SETTLE),
        .SINC_SETTLE_CYC(SETTLE)) dut_u (.clk(clk), .rst_n(rst_n),
        .reset_pin_n(reset_pin_n), .powerdown_n(powerdown_n), .supply_ok(supply_ok),
        .sync_pin(sync_pin), .serial_in(serial_in), .filter_fir(filter_fir),
        .cont_sync_mode(cont_sync_mode), .sample(sample), .sample_ready(sample_ready),
        .dout(dout), .result_ready_n(result_ready_n));
    host_model host_u (.clk(clk), .dout(dout), .serial_in(serial_in));

    // 50 MHz master clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Summary, verdict and end of run
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Expected word for a filter result
    function automatic logic [31:0] fmt(input logic signed [32:0] x, input logic fir);
        if (!fir) return x[31:0]; // Sinc halves, no clip
        if (x > 33'sh03FFFFFFF) return 32'h7FFFFFFF; // Positive clip
        if (x < -33'sh040000000) return 32'h80000000; // Negative clip
        return {x[30:0], x[32]}; // Low bit repeats the sign
    endfunction : fmt

    // Inputs move one nanosecond after the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    // Offer one result and hold it until taken
    task automatic push(input logic signed [32:0] x);
        sample.valid = 1'b1;
        sample.value = x;
        n = 0;
        while (sample_ready !== 1'b1 && n < 4000) begin
            step(1);
            n++;
        end
        step(1);
        sample.valid = 1'b0;
    endtask : push

    // Wait for ready high, then for the next publish
    task automatic wait_fall();
        n = 0;
        while (result_ready_n === 1'b0 && n < 3000) begin
            step(1);
            n++;
        end
        while (result_ready_n !== 1'b0 && n < 3000) begin
            step(1);
            n++;
        end
        check("ready fall", 40'h0, 40'(n >= 3000));
    endtask : wait_fall

    task automatic read_chk(input logic signed [32:0] x, input int bits);
        logic [39:0] exp;
        exp = {fmt(x, filter_fir), 8'h00} >> (40 - bits);
        wait_fall();
        host_u.shift(bits, 40'h0, rx);
        check("result word", exp, rx);
    endtask : read_chk

    // First word after a restart lands in the settle window; the next must arrive
    task automatic after_event();
        push(33'($random(seed)) >>> 2);
        step(SETTLE);
        v = 33'($random(seed)) >>> 2;
        push(v);
        read_chk(v, 32);
    endtask : after_event

    // Hang guard, about twice the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        seed = 32'h2a526bf9;
        {n_fail, compares} = '0;
        {rst_n, supply_ok, sync_pin, cont_sync_mode, sample} = '0;
        {reset_pin_n, powerdown_n, filter_fir} = 3'b111;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        step(4);
        supply_ok = 1'b1;
        step(6);
        check("ready during count", 40'h0, 40'(sample_ready));
        step(SETTLE + 2 * PER);
        vals = '{33'sh03FFFFFFF, 33'sh040000000, 33'sh1C0000000, 33'sh1BFFFFFFF,
            33'sh000000001, 33'sh1FFFFFFFF, 33'sh000000000, 33'sh100000000};
        for (int i = 0; i < 16; i++) begin
            v = (i < 8) ? vals[i] : 33'($random(seed)) >>> (i % 3);
            push(v);
            read_chk(v, (i == 5) ? 40 : (i == 6) ? 24 : 32);
        end
        $display("fir format test done");
        filter_fir = 1'b0;
        host_u.half = 5;
        for (int i = 0; i < 4; i++) begin
            v = 33'($random(seed));
            push(v);
            read_chk(v, 32);
        end
        filter_fir = 1'b1;
        host_u.half = 4;
        $display("sinc format test done");
        for (int i = 0; i < 8; i++) vals[i] = 33'($random(seed)) >>> 2;
        push(vals[0]);
        wait_fall();
        sample.valid = 1'b1;
        n = 0;
        while (sample_ready === 1'b1 && n < 12) begin
            sample.value = vals[n % 8];
            step(1);
            n++;
        end
        sample.valid = 1'b0;
        check("words accepted", 40'(FIFO_DEPTH), 40'(n));
        for (int i = 0; i < 8; i++) read_chk(vals[i], 32);
        $display("buffer test done");
        host_u.shift(8, {OP_STOP_STREAM, 32'h0}, rx);
        push(vals[1]);
        n = 0;
        repeat (2 * PER) begin
            n += int'(result_ready_n !== 1'b1);
            step(1);
        end
        check("ready while stopped", 40'h0, 40'(n));
        host_u.shift(8, {OP_READ, 32'h0}, rx);
        push(vals[2]);
        read_chk(vals[2], 32);
        host_u.shift(8, {OP_START_STREAM, 32'h0}, rx);
        push(vals[3]);
        read_chk(vals[3], 32);
        $display("stream mode test done");
        for (int e = 0; e < 7; e++) begin
            if (e < 3) host_u.shift(8, {OP_STOP_STREAM, 32'h0}, rx);
            case (e)
                0, 1: begin
                    reset_pin_n = (e != 0);
                    powerdown_n = (e != 1);
                    step(6);
                    check("outputs held", 40'h1, 40'({dout, sample_ready, result_ready_n}));
                    reset_pin_n = 1'b1;
                    powerdown_n = 1'b1;
                end
                2: host_u.shift(8, {OP_RESET, 32'h0}, rx);
                3: begin
                    sync_pin = 1'b1;
                    step(4);
                    sync_pin = 1'b0; // High phase four clocks, low phase far longer
                end
                4: host_u.shift(8, {OP_SYNC, 32'h0}, rx);
                6: begin
                    cont_sync_mode = 1'b1;
                    sync_pin = 1'b1;
                    step(4);
                    sync_pin = 1'b0; // First rise after mode set syncs
                    push(33'($random(seed)));
                    wait_fall();
                    host_u.shift(32, 40'h0, rx);
                    check("blanked word", 40'h0, rx);
                end
                default: begin
                    host_u.shift(8, {OP_STANDBY, 32'h0}, rx);
                    step(8);
                    check("ready in standby", 40'h0, 40'(sample_ready));
                    host_u.shift(8, {OP_RESUME, 32'h0}, rx);
                end
            endcase
            after_event();
            $display("restart test %0d done", e);
        end
        give_verdict();
    end
endmodule : tb
